/* File: rtl/tlbp_regs.vh */
`ifndef TLBP_REGS_VH
`define TLBP_REGS_VH
//
// Notes on behaviour
// - Data miss sets entry valid bit
// - Effective page bits 23-27 read zero
// - Control read gives level-two index by mode
// - Protection group cleared to zero on miss
// - Guarded bit cleared on miss
// - Level-one page size decode, cleared on miss
// - Write-through set on miss, reads zero
// - Valid set on miss, reads zero
// - Page port write loads selected entry
// - Decode 1K-resolution subpage protection codes
// - Decode extended or architectural protection
// - Clear change bit faults a granted write at 4K resolution
// - Subpage valid bits, privilege check mode
// - Large page select chooses 4K/16K
// - Global mapping skips space tag compare
// - Cache-inhibit and valid stored with entry
// - Camera readback write captures pointed entry
// - RAM readback writes ignored, all readable
// - Camera readback fields, 3-bit size code
// - Bits 28-31 give subpage validity
// - RAM readback 0 layout, inverted group
// - RAM readback 1 problem fetch, valid, guarded

// ----------------------------------------
// Special-register select codes
// ----------------------------------------
`define TLBP_SEL_EPN      4'h0
`define TLBP_SEL_TWC      4'h1
`define TLBP_SEL_RPN      4'h2
`define TLBP_SEL_CAM      4'h3
`define TLBP_SEL_RAM0     4'h4
`define TLBP_SEL_RAM1     4'h5

// ----------------------------------------
// Field positions (big-endian bit 0 is bit 31 here)
// ----------------------------------------
`define TLBP_EPN_PAGE     31:10
`define TLBP_EPN_EV       9
`define TLBP_EPN_SPACE    3:0
`define TLBP_TWC_BASE     31:12
`define TLBP_TWC_APG      8:5
`define TLBP_TWC_G        4
`define TLBP_TWC_PS       3:2
`define TLBP_TWC_WT       1
`define TLBP_TWC_V        0
`define TLBP_RPN_PAGE     31:12
`define TLBP_RPN_PP       11:4
`define TLBP_RPN_LPS      3
`define TLBP_RPN_SH       2
`define TLBP_RPN_CI       1
`define TLBP_RPN_V        0

// ----------------------------------------
// Values forced on a data miss
// ----------------------------------------
`define TLBP_MISS_APG     4'h0
`define TLBP_MISS_PS      2'h0
`define TLBP_MISS_G       1'b0
`define TLBP_MISS_WT      1'b1
`define TLBP_MISS_V       1'b1
`define TLBP_MISS_EV      1'b1

// ----------------------------------------
// Page size codes
// ----------------------------------------
`define TLBP_PS_SMALL     2'h0
`define TLBP_PS_512K      2'h1
`define TLBP_PS_8M        2'h3
`define TLBP_DPS_4K       3'h0
`define TLBP_DPS_16K      3'h1
`define TLBP_DPS_512K     3'h3
`define TLBP_DPS_8M       3'h7
`define TLBP_DPS_RSVD     3'h2
`define TLBP_RAM1_RSVD    26'h3FFFFFF
`endif

/* File: rtl/tlbp_prot_dec.v */
`timescale 1ns/1ps
`include "tlbp_regs.vh"
// Protection code decode into read/write grants for both modes
module tlbp_prot_dec (
  // Code and mode
  input  wire [1:0] i_code,
  input  wire       i_res_1k,
  input  wire       i_extended,
  // Grants
  output reg        o_priv_rd,
  output reg        o_priv_wr,
  output reg        o_prob_rd,
  output reg        o_prob_wr
);

  // ----------------------------------------
  // Decode table
  // ----------------------------------------
  // Reserved extended codes grant nothing, the safe reading
  always @* begin
    o_priv_rd = 1'b0;
    o_priv_wr = 1'b0;
    o_prob_rd = 1'b0;
    o_prob_wr = 1'b0;
    if (i_res_1k) begin
      // 1K resolution: privileged gets read-write above code 00
      o_priv_rd = (i_code != 2'h0);
      o_priv_wr = (i_code != 2'h0);
      o_prob_rd = i_code[1];
      o_prob_wr = (i_code == 2'h3);
    end else if (i_extended) begin
      // Extended: only 01 grants privileged read
      o_priv_rd = (i_code == 2'h1);
    end else begin
      // Architectural encoding
      case (i_code)
        2'h0: begin
          o_priv_rd = 1'b1;
          o_priv_wr = 1'b1;
        end
        2'h1: begin
          o_priv_rd = 1'b1;
          o_priv_wr = 1'b1;
          o_prob_rd = 1'b1;
        end
        2'h2: begin
          o_priv_rd = 1'b1;
          o_priv_wr = 1'b1;
          o_prob_rd = 1'b1;
          o_prob_wr = 1'b1;
        end
        default: begin
          o_priv_rd = 1'b1;
          o_prob_rd = 1'b1;
        end
      endcase
    end
  end

endmodule

/* File: rtl/tlbp_top.v */
`timescale 1ns/1ps
`include "tlbp_regs.vh"
// Data TLB load port, lookup and data-side debug readback
module tlbp_top #(
  parameter ENTRIES = 8,
  parameter IDX_W   = 3
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_reset_n,
  // Special-register move port
  input  wire             i_spr_wr,
  input  wire             i_spr_rd,
  input  wire [3:0]       i_spr_sel,
  input  wire [31:0]      i_spr_wdata,
  output reg  [31:0]      o_spr_rdata,
  output reg              o_spr_rvalid,
  // MMU control inputs
  input  wire             i_tablewalk_assist_mode,
  input  wire             i_subpage_priv_check_mode,
  input  wire             i_prot_res_1k,
  input  wire             i_prot_extended,
  input  wire [IDX_W-1:0] i_load_index,
  input  wire [IDX_W-1:0] i_entry_pointer,
  input  wire [3:0]       i_current_space_field,
  // Miss event
  input  wire             i_dtlb_miss,
  input  wire [31:0]      i_miss_ea,
  // Lookup request
  input  wire             i_lk_req,
  input  wire [31:0]      i_lk_ea,
  input  wire             i_lk_priv,
  input  wire             i_lk_write,
  // Lookup answer
  output reg              o_lk_valid,
  output reg              o_lk_hit,
  output reg  [19:0]      o_lk_rpn,
  output reg              o_lk_uncached,
  output reg              o_lk_guarded,
  output reg              o_lk_write_through,
  output reg              o_lk_prot_fault,
  output reg              o_lk_change_fault
);

  // ----------------------------------------
  // Staging registers
  // ----------------------------------------
  reg  [21:0] epn_page;        // Effective page of last miss or write
  reg         epn_ev;          // Entry valid bit
  reg  [3:0]  epn_space;       // Address space tag
  reg  [19:0] twc_base;        // Second-level base
  reg  [3:0]  twc_apg;         // Protection group
  reg         twc_g;           // Guarded
  reg  [1:0]  twc_ps;          // Level-one page size
  reg         twc_wt;          // Write-through
  reg         twc_v;           // Valid
  reg  [31:0] rpn_last;        // Last value written to the page port

  // ----------------------------------------
  // Entry storage
  // ----------------------------------------
  reg  [21:0] e_epn   [0:ENTRIES-1];
  reg  [3:0]  e_space [0:ENTRIES-1];
  reg  [3:0]  e_apg   [0:ENTRIES-1];
  reg  [1:0]  e_ps    [0:ENTRIES-1];
  reg  [19:0] e_rpn   [0:ENTRIES-1];
  reg  [7:0]  e_pp    [0:ENTRIES-1];
  reg  [ENTRIES-1:0] e_valid;  // Both valid bits and entry valid
  reg  [ENTRIES-1:0] e_g;
  reg  [ENTRIES-1:0] e_wt;
  reg  [ENTRIES-1:0] e_lps;
  reg  [ENTRIES-1:0] e_sh;
  reg  [ENTRIES-1:0] e_ci;
  wire [ENTRIES-1:0] e_match;  // Per-entry lookup match

  // ----------------------------------------
  // Readback registers
  // ----------------------------------------
  reg  [31:0] cam_rb;          // Camera readback
  reg  [31:0] ram0_rb;         // RAM readback 0
  reg  [31:0] ram1_rb;         // RAM readback 1

  // Decoded strobes
  wire wr_epn = i_spr_wr && (i_spr_sel == `TLBP_SEL_EPN);
  wire wr_twc = i_spr_wr && (i_spr_sel == `TLBP_SEL_TWC);
  wire wr_rpn = i_spr_wr && (i_spr_sel == `TLBP_SEL_RPN);
  wire wr_cam = i_spr_wr && (i_spr_sel == `TLBP_SEL_CAM);

  // Level-two index from the staged page
  // The page register holds address bits 31:10, so bit 12 of the word is bit 2 here
  wire [9:0] l2_index = i_tablewalk_assist_mode ? epn_page[11:2]
                                                : epn_page[9:0];

  // ----------------------------------------
  // Effective page register
  // ----------------------------------------
  // A miss in the same cycle as a write wins, so the miss is not lost
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      epn_page  <= 22'h000000;
      epn_ev    <= 1'b0;
      epn_space <= 4'h0;
    end else if (i_dtlb_miss) begin
      epn_page  <= i_miss_ea[31:10];
      epn_ev    <= `TLBP_MISS_EV;
      epn_space <= i_current_space_field;
    end else if (wr_epn) begin
      // Reserved bits are simply not stored
      epn_page  <= i_spr_wdata[`TLBP_EPN_PAGE];
      epn_ev    <= i_spr_wdata[`TLBP_EPN_EV];
      epn_space <= i_spr_wdata[`TLBP_EPN_SPACE];
    end
  end

  // ----------------------------------------
  // Tablewalk control register
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      twc_base <= 20'h00000;
      twc_apg  <= 4'h0;
      twc_g    <= 1'b0;
      twc_ps   <= 2'h0;
      twc_wt   <= 1'b0;
      twc_v    <= 1'b0;
    end else begin
      if (wr_twc) begin
        twc_base <= i_spr_wdata[`TLBP_TWC_BASE];
      end
      if (i_dtlb_miss) begin
        twc_apg <= `TLBP_MISS_APG;
        twc_g   <= `TLBP_MISS_G;
        twc_ps  <= `TLBP_MISS_PS;
        twc_wt  <= `TLBP_MISS_WT;
        twc_v   <= `TLBP_MISS_V;
      end else if (wr_twc) begin
        twc_apg <= i_spr_wdata[`TLBP_TWC_APG];
        twc_g   <= i_spr_wdata[`TLBP_TWC_G];
        twc_ps  <= i_spr_wdata[`TLBP_TWC_PS];
        twc_wt  <= i_spr_wdata[`TLBP_TWC_WT];
        twc_v   <= i_spr_wdata[`TLBP_TWC_V];
      end
    end
  end

  // ----------------------------------------
  // Page port shadow, for reads
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rpn_last <= 32'h00000000;
    end else if (wr_rpn) begin
      rpn_last <= i_spr_wdata;
    end
  end

  // ----------------------------------------
  // Entry load and match, one slice per entry
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : g_entry
      reg [19:0] size_mask;    // Page bits that take part in the compare
      // Larger pages drop low page bits from the compare
      always @* begin
        case (e_ps[gi])
          `TLBP_PS_512K: size_mask = 20'hFFF80;
          `TLBP_PS_8M:   size_mask = 20'hFF800;
          default:       size_mask = e_lps[gi] ? 20'hFFFFC : 20'hFFFFF;
        endcase
      end
      assign e_match[gi] = e_valid[gi]
                         && (((e_epn[gi][21:2] ^ i_lk_ea[31:12]) & size_mask) == 20'h00000)
                         && (e_sh[gi] || (e_space[gi] == i_current_space_field));

      // Page port write commits staged values with the written ones
      always @(posedge i_clk) begin
        if (!i_reset_n) begin
          e_valid[gi] <= 1'b0;
          e_epn[gi]   <= 22'h000000;
          e_space[gi] <= 4'h0;
          e_apg[gi]   <= 4'h0;
          e_ps[gi]    <= 2'h0;
          e_rpn[gi]   <= 20'h00000;
          e_pp[gi]    <= 8'h00;
          e_g[gi]     <= 1'b0;
          e_wt[gi]    <= 1'b0;
          e_lps[gi]   <= 1'b0;
          e_sh[gi]    <= 1'b0;
          e_ci[gi]    <= 1'b0;
        end else if (wr_rpn && (i_load_index == gi)) begin
          e_epn[gi]   <= epn_page;
          e_space[gi] <= epn_space;
          e_apg[gi]   <= twc_apg;
          e_ps[gi]    <= twc_ps;
          e_g[gi]     <= twc_g;
          e_wt[gi]    <= twc_wt;
          e_rpn[gi]   <= i_spr_wdata[`TLBP_RPN_PAGE];
          e_pp[gi]    <= i_spr_wdata[`TLBP_RPN_PP];
          e_lps[gi]   <= i_spr_wdata[`TLBP_RPN_LPS];
          e_sh[gi]    <= i_spr_wdata[`TLBP_RPN_SH];
          e_ci[gi]    <= i_spr_wdata[`TLBP_RPN_CI];
          e_valid[gi] <= epn_ev && twc_v && i_spr_wdata[`TLBP_RPN_V];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Lookup: lowest matching entry wins
  // ----------------------------------------
  reg             hit;
  reg [IDX_W-1:0] hit_idx;
  integer         k;
  always @* begin
    hit     = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
      if (e_match[k]) begin
        hit     = 1'b1;
        hit_idx = k[IDX_W-1:0];
      end
    end
  end

  // Subpage selection for the hit entry
  wire [1:0] lk_sp    = i_lk_ea[11:10];
  wire [7:0] lk_pp    = e_pp[hit_idx];
  wire [1:0] lk_code  = i_prot_res_1k ? lk_pp[7 - 2 * lk_sp -: 2] : lk_pp[7:6];
  wire       lk_change = i_prot_res_1k || lk_pp[5];
  // Subpage valid bits sit in the last two code fields at 4K resolution
  wire       lk_sp_ok = i_prot_res_1k ? 1'b1
                      : i_subpage_priv_check_mode ? (i_lk_priv ? lk_pp[3] : lk_pp[2])
                      : lk_pp[3 - lk_sp];
  wire       lk_priv_rd;
  wire       lk_priv_wr;
  wire       lk_prob_rd;
  wire       lk_prob_wr;

  tlbp_prot_dec u_lk_dec (
    .i_code     (lk_code),
    .i_res_1k   (i_prot_res_1k),
    .i_extended (i_prot_extended),
    .o_priv_rd  (lk_priv_rd),
    .o_priv_wr  (lk_priv_wr),
    .o_prob_rd  (lk_prob_rd),
    .o_prob_wr  (lk_prob_wr)
  );

  wire lk_grant = i_lk_priv ? (i_lk_write ? lk_priv_wr : lk_priv_rd)
                            : (i_lk_write ? lk_prob_wr : lk_prob_rd);

  // Lookup answer registered one cycle after the request
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_lk_valid         <= 1'b0;
      o_lk_hit           <= 1'b0;
      o_lk_rpn           <= 20'h00000;
      o_lk_uncached      <= 1'b0;
      o_lk_guarded       <= 1'b0;
      o_lk_write_through <= 1'b0;
      o_lk_prot_fault    <= 1'b0;
      o_lk_change_fault  <= 1'b0;
    end else begin
      o_lk_valid <= i_lk_req;
      if (i_lk_req) begin
        o_lk_hit           <= hit && lk_sp_ok;
        o_lk_rpn           <= e_rpn[hit_idx];
        o_lk_uncached      <= e_ci[hit_idx];
        o_lk_guarded       <= e_g[hit_idx];
        o_lk_write_through <= e_wt[hit_idx];
        o_lk_prot_fault    <= hit && lk_sp_ok && !lk_grant;
        o_lk_change_fault  <= hit && lk_sp_ok && lk_grant && i_lk_write
                              && !lk_change;
      end
    end
  end

  // ----------------------------------------
  // Debug view of the pointed entry
  // ----------------------------------------
  wire [7:0] dp_pp  = e_pp[i_entry_pointer];
  wire       dp_v   = e_valid[i_entry_pointer];
  reg  [2:0] dp_ps;            // Three-bit size code
  always @* begin
    case (e_ps[i_entry_pointer])
      `TLBP_PS_SMALL: dp_ps = e_lps[i_entry_pointer] ? `TLBP_DPS_16K : `TLBP_DPS_4K;
      `TLBP_PS_512K:  dp_ps = `TLBP_DPS_512K;
      `TLBP_PS_8M:    dp_ps = `TLBP_DPS_8M;
      default:        dp_ps = `TLBP_DPS_RSVD;
    endcase
  end

  // Per-subpage validity and fetch grants
  wire [3:0] dp_spv;
  wire [3:0] dp_sfp;
  wire [3:0] dp_ufp;
  genvar gs;
  generate
    for (gs = 0; gs < 4; gs = gs + 1) begin : g_sub
      wire [1:0] code = i_prot_res_1k ? dp_pp[7 - 2 * gs -: 2] : dp_pp[7:6];
      wire       prd;
      wire       prb;
      tlbp_prot_dec u_dec (
        .i_code     (code),
        .i_res_1k   (i_prot_res_1k),
        .i_extended (i_prot_extended),
        .o_priv_rd  (prd),
        .o_priv_wr  (),
        .o_prob_rd  (prb),
        .o_prob_wr  ()
      );
      // Bit 3 of each nibble is subpage 0
      assign dp_spv[3 - gs] = dp_v && (i_prot_res_1k || (i_subpage_priv_check_mode
                              ? (dp_pp[3] || dp_pp[2]) : dp_pp[3 - gs]));
      assign dp_sfp[3 - gs] = dp_spv[3 - gs] && prd;
      assign dp_ufp[3 - gs] = dp_spv[3 - gs] && prb;
    end
  endgenerate

  // ----------------------------------------
  // Readback capture
  // ----------------------------------------
  // Captured once per trigger so later reloads leave the view alone
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      cam_rb  <= 32'h00000000;
      ram0_rb <= 32'h00000000;
      ram1_rb <= {`TLBP_RAM1_RSVD, 6'h00};
    end else if (wr_cam) begin
      cam_rb  <= {e_epn[i_entry_pointer][21:2], dp_ps,
                  e_space[i_entry_pointer], e_sh[i_entry_pointer], dp_spv};
      ram0_rb <= {e_rpn[i_entry_pointer], dp_ps, e_ci[i_entry_pointer],
                  ~e_apg[i_entry_pointer], dp_sfp};
      ram1_rb <= {`TLBP_RAM1_RSVD, dp_ufp, dp_v, e_g[i_entry_pointer]};
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // RAM readback writes land nowhere; unmapped selects read zero
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_spr_rdata  <= 32'h00000000;
      o_spr_rvalid <= 1'b0;
    end else begin
      o_spr_rvalid <= i_spr_rd;
      if (i_spr_rd) begin
        case (i_spr_sel)
          `TLBP_SEL_EPN:  o_spr_rdata <= {epn_page, epn_ev, 5'h00, epn_space};
          `TLBP_SEL_TWC:  o_spr_rdata <= {twc_base, l2_index, 2'h0};
          `TLBP_SEL_RPN:  o_spr_rdata <= rpn_last;
          `TLBP_SEL_CAM:  o_spr_rdata <= cam_rb;
          `TLBP_SEL_RAM0: o_spr_rdata <= ram0_rb;
          `TLBP_SEL_RAM1: o_spr_rdata <= ram1_rb;
          default:        o_spr_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

/* File: testbench/tlbp_top_props.sv */
`timescale 1ns/1ps
`include "tlbp_regs.vh"
// Port-level checks on the move port and the lookup answer
module tlbp_top_props (
  // Clock and reset
  input wire        i_clk,
  input wire        i_reset_n,
  // Move port
  input wire        i_spr_wr,
  input wire        i_spr_rd,
  input wire [3:0]  i_spr_sel,
  input wire [31:0] o_spr_rdata,
  input wire        o_spr_rvalid,
  // Miss and lookup
  input wire        i_dtlb_miss,
  input wire [31:0] i_miss_ea,
  input wire        i_lk_req,
  input wire        i_lk_write,
  input wire        o_lk_valid,
  input wire        o_lk_hit,
  input wire        o_lk_prot_fault,
  input wire        o_lk_change_fault
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Page of the last miss; an own write drops it, so a stale miss is not expected
  reg        seen;
  reg [21:0] page;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      seen <= 1'b0;
      page <= 22'h0;
    end else if (i_dtlb_miss) begin
      seen <= 1'b1;
      page <= i_miss_ea[31:10];
    end else if (i_spr_wr && i_spr_sel == `TLBP_SEL_EPN) begin
      seen <= 1'b0;
    end
  end
  a_read_answer: assert property (1'b1 |=> o_spr_rvalid == $past(i_spr_rd))
    else $error("read answer pulse wrong");
  a_rdata_stands: assert property (!i_spr_rd |=> $stable(o_spr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_spr_rd && i_spr_sel > `TLBP_SEL_RAM1 |=> o_spr_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_epn_reserved: assert property (
    i_spr_rd && i_spr_sel == `TLBP_SEL_EPN |=> o_spr_rdata[8:4] == 5'h0)
    else $error("page register reserved bits set");
  a_twc_low_zero: assert property (
    i_spr_rd && i_spr_sel == `TLBP_SEL_TWC |=> o_spr_rdata[1:0] == 2'h0)
    else $error("control low bits not zero");
  a_miss_page: assert property (
    i_spr_rd && i_spr_sel == `TLBP_SEL_EPN && seen && !i_dtlb_miss && !i_spr_wr
    |=> o_spr_rdata[31:9] == {page, 1'b1})
    else $error("miss page or valid bit wrong");
  a_ram1_ones: assert property (
    i_spr_rd && i_spr_sel == `TLBP_SEL_RAM1 |=> o_spr_rdata[31:6] == 26'h3FFFFFF)
    else $error("second readback upper bits not ones");
  a_lk_answer: assert property (1'b1 |=> o_lk_valid == $past(i_lk_req))
    else $error("lookup answer pulse wrong");
  a_lk_hold: assert property (!i_lk_req |=> $stable(o_lk_hit) && $stable(o_lk_prot_fault))
    else $error("lookup result moved without a request");
  a_change_write: assert property (
    o_lk_valid && o_lk_change_fault |-> $past(i_lk_write) && o_lk_hit && !o_lk_prot_fault)
    else $error("change fault on a read or refused access");
endmodule

bind tlbp_top tlbp_top_props i_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_spr_wr(i_spr_wr), .i_spr_rd(i_spr_rd),
  .i_spr_sel(i_spr_sel), .o_spr_rdata(o_spr_rdata), .o_spr_rvalid(o_spr_rvalid),
  .i_dtlb_miss(i_dtlb_miss), .i_miss_ea(i_miss_ea), .i_lk_req(i_lk_req),
  .i_lk_write(i_lk_write), .o_lk_valid(o_lk_valid), .o_lk_hit(o_lk_hit),
  .o_lk_prot_fault(o_lk_prot_fault), .o_lk_change_fault(o_lk_change_fault)
);

/* File: testbench/tlbp_core_model.sv */
`timescale 1ns/1ps
// Core side of the move port: one-edge strobes, released lines show inverted data
module tlbp_core_model (
  // Clock and answer
  input  wire        i_clk,
  input  wire [31:0] i_rdata,
  input  wire        i_rvalid,
  // Move request
  output reg         o_wr    = 1'b0,
  output reg         o_rd    = 1'b0,
  output reg  [3:0]  o_sel   = 4'h0,
  output reg  [31:0] o_wdata = 32'h0
);
  // Write: strobe stands for one edge, then data is scrambled so no stale value lingers
  task mt_write(input [3:0] s, input [31:0] d);
    begin
      @(posedge i_clk);
      o_wr    <= 1'b1;
      o_sel   <= s;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_sel   <= ~s;
      o_wdata <= ~d;
    end
  endtask
  // Read: answer is taken while its one-cycle valid pulse stands
  task mf_read(input [3:0] s, output [31:0] d, output ok);
    begin
      @(posedge i_clk);
      o_rd  <= 1'b1;
      o_sel <= s;
      @(posedge i_clk);
      o_rd  <= 1'b0;
      o_sel <= ~s;
      #1;
      ok = (i_rvalid === 1'b1);
      d  = i_rdata;
    end
  endtask
endmodule

/* File: testbench/tlbp_top_tb.sv */
`timescale 1ns/1ps
`include "tlbp_regs.vh"
// Move-port sequences; expected words worked out from the field layouts
module tlbp_top_tb;
  reg         clk = 1'b0, reset_n = 1'b0, tw_mode = 1'b1, res_1k = 1'b0, ext = 1'b0;
  reg         miss = 1'b0, lk_req = 1'b0, lk_priv = 1'b0, lk_write = 1'b0, ok;
  reg         spc_mode = 1'b0;
  reg  [2:0]  load_idx = 3'h0, ptr = 3'h0;
  reg  [3:0]  space = 4'h6;
  reg  [31:0] miss_ea = 32'h0, lk_ea = 32'h0, got;
  wire        spr_wr, spr_rd, rvalid, lk_valid, lk_hit, lk_unc, lk_grd, lk_wt, lk_pf, lk_cf;
  wire [3:0]  spr_sel;
  wire [31:0] spr_wdata, spr_rdata;
  wire [19:0] lk_rpn;
  integer     mismatches = 0, check_count = 0, k;
  always #25 clk = ~clk;
  tlbp_core_model i_core (.i_clk(clk), .i_rdata(spr_rdata), .i_rvalid(rvalid),
    .o_wr(spr_wr), .o_rd(spr_rd), .o_sel(spr_sel), .o_wdata(spr_wdata));
  tlbp_top #(.ENTRIES(8), .IDX_W(3)) i_dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_spr_wr(spr_wr), .i_spr_rd(spr_rd),
    .i_spr_sel(spr_sel), .i_spr_wdata(spr_wdata), .o_spr_rdata(spr_rdata),
    .o_spr_rvalid(rvalid), .i_tablewalk_assist_mode(tw_mode),
    .i_subpage_priv_check_mode(spc_mode), .i_prot_res_1k(res_1k), .i_prot_extended(ext),
    .i_load_index(load_idx), .i_entry_pointer(ptr), .i_current_space_field(space),
    .i_dtlb_miss(miss), .i_miss_ea(miss_ea), .i_lk_req(lk_req), .i_lk_ea(lk_ea),
    .i_lk_priv(lk_priv), .i_lk_write(lk_write), .o_lk_valid(lk_valid), .o_lk_hit(lk_hit),
    .o_lk_rpn(lk_rpn), .o_lk_uncached(lk_unc), .o_lk_guarded(lk_grd),
    .o_lk_write_through(lk_wt), .o_lk_prot_fault(lk_pf), .o_lk_change_fault(lk_cf));
  // Word compare, four-state so an unknown never matches
  task chk32(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  // Read a register; a missing answer pulse poisons the word
  task rd_chk(input [3:0] s, input [31:0] e);
    begin
      i_core.mf_read(s, got, ok);
      if (!ok)
        got = 32'hXXXXXXXX;
      chk32(got, e);
    end
  endtask
  // Miss pulse for one edge
  task do_miss(input [31:0] ea);
    begin
      @(posedge clk);
      miss    <= 1'b1;
      miss_ea <= ea;
      @(posedge clk);
      miss    <= 1'b0;
      miss_ea <= ~ea;
    end
  endtask
  // Lookup; answer word {valid,hit,unc,grd,wt,prot,chg,0,rpn} under a mask
  task look(input [31:0] ea, input p, input w, input [31:0] e, input [31:0] m);
    begin
      @(posedge clk);
      lk_req   <= 1'b1;
      lk_ea    <= ea;
      lk_priv  <= p;
      lk_write <= w;
      @(posedge clk);
      lk_req <= 1'b0;
      lk_ea  <= ~ea;
      #1;
      chk32({lk_valid, lk_hit, lk_unc, lk_grd, lk_wt, lk_pf, lk_cf, 5'h0, lk_rpn} & m, e & m);
    end
  endtask
  // Verdict and end of run
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Watchdog: the sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    mismatches = mismatches + 1;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`TLBP_SEL_RAM1, 32'hFFFFFFC0);
    rd_chk(`TLBP_SEL_CAM, 32'h0);
    rd_chk(4'hA, 32'h0);
    $display("test reset values done");
    i_core.mt_write(`TLBP_SEL_EPN, 32'hABCDE1F3);
    rd_chk(`TLBP_SEL_EPN, 32'hABCDE003);
    do_miss(32'h12345678);
    rd_chk(`TLBP_SEL_EPN, 32'h12345606);
    i_core.mt_write(`TLBP_SEL_TWC, 32'hFEDCB0B5);
    rd_chk(`TLBP_SEL_TWC, 32'hFEDCBD14);
    @(posedge clk);
    tw_mode <= 1'b0;
    rd_chk(`TLBP_SEL_TWC, 32'hFEDCB454);
    $display("test staging registers done");
    i_core.mt_write(`TLBP_SEL_RPN, 32'h0ABCD2F7);
    i_core.mt_write(`TLBP_SEL_CAM, 32'h5A5A5A5A);
    rd_chk(`TLBP_SEL_CAM, 32'h123456DF);
    rd_chk(`TLBP_SEL_RAM0, 32'h0ABCD7AF);
    rd_chk(`TLBP_SEL_RAM1, 32'hFFFFFFC3);
    rd_chk(`TLBP_SEL_RPN, 32'h0ABCD2F7);
    i_core.mt_write(`TLBP_SEL_RAM0, 32'h0);
    i_core.mt_write(`TLBP_SEL_RAM1, 32'h0);
    i_core.mt_write(`TLBP_SEL_RPN, 32'h111112F7);
    rd_chk(`TLBP_SEL_RAM0, 32'h0ABCD7AF);
    rd_chk(`TLBP_SEL_RAM1, 32'hFFFFFFC3);
    $display("test load and readback done");
    do_miss(32'h00020000);
    load_idx <= 3'h1;
    ptr      <= 3'h1;
    i_core.mt_write(`TLBP_SEL_RPN, 32'h007778F1);
    i_core.mt_write(`TLBP_SEL_CAM, 32'h0);
    rd_chk(`TLBP_SEL_CAM, 32'h000200CF);
    rd_chk(`TLBP_SEL_RAM0, 32'h007770FF);
    rd_chk(`TLBP_SEL_RAM1, 32'hFFFFFFFE);
    $display("test miss defaults done");
    look(32'h00020400, 1'b1, 1'b0, 32'hC8000777, 32'hFFFFFFFF);
    look(32'h00020400, 1'b1, 1'b1, 32'hCA000777, 32'hFFFFFFFF);
    @(posedge clk);
    space <= 4'h7;
    look(32'h00020400, 1'b1, 1'b0, 32'h80000000, 32'hC0000000);
    look(32'h12345000, 1'b1, 1'b0, 32'hF0000000, 32'hFFF00000);
    @(posedge clk);
    space <= 4'h6;
    ext   <= 1'b1;
    look(32'h12345000, 1'b0, 1'b1, 32'hF4000000, 32'hFFF00000);
    look(32'h00020400, 1'b1, 1'b0, 32'hCC000777, 32'hFFFFFFFF);
    $display("test lookup done");
    @(posedge clk);
    ext    <= 1'b0;
    res_1k <= 1'b1;
    do_miss(32'h00030000);
    load_idx <= 3'h2;
    i_core.mt_write(`TLBP_SEL_RPN, 32'h009991B1);
    // Subpage k carries code k; problem read needs 10 or 11, privileged write any but 00
    for (k = 0; k < 4; k = k + 1) begin
      look(32'h00030000 | (k << 10), 1'b0, 1'b0,
        {(k < 2) ? 7'h66 : 7'h64, 25'h00999}, 32'hFFFFFFFF);
      look(32'h00030000 | (k << 10), 1'b1, 1'b1,
        {(k == 0) ? 7'h66 : 7'h64, 25'h00999}, 32'hFFFFFFFF);
    end
    $display("test fine protection done");
    // Subpage valid 1000 with check mode on: only privileged accesses hit
    @(posedge clk);
    res_1k   <= 1'b0;
    spc_mode <= 1'b1;
    i_core.mt_write(`TLBP_SEL_RPN, 32'h00999A81);
    look(32'h00030000, 1'b1, 1'b0, 32'hC8000999, 32'hFFFFFFFF);
    look(32'h00030000, 1'b0, 1'b0, 32'h80000000, 32'hC6000000);
    look(32'h00030000, 1'b1, 1'b1, 32'hC8000999, 32'hFFFFFFFF);
    $display("test subpage check mode done");
    print_verdict;
  end
endmodule
